// file: core/fcsp_pkg.sv
// Shared constants and types of the flash control, status and protect block
package fcsp_pkg;

   // ==========================================================
   // Register map and field layout
   localparam logic [7:0]  SEC_CTRL_OFS   = 8'h10;
   localparam logic [7:0]  OP_STATUS_OFS  = 8'h20;
   localparam logic [7:0]  PROT_STAT_OFS  = 8'h30;
   localparam int          SEC_EN_BIT     = 0;
   localparam int          READY_BIT      = 0;
   localparam int          NUM_BLOCKS     = 4;
   localparam logic [31:0] SEC_CTRL_RST   = 32'h0000_0001;
   localparam logic [31:0] OP_STATUS_RST  = 32'h0000_0001;
   localparam logic [31:0] UNLOCK_CODE    = 32'hA74A_9D23;

   // ==========================================================
   // Timing
   localparam int          CLK_PERIOD_NS  = 40;
   localparam int          UNLOCK_WIN_CLK = 16;
   localparam logic [4:0]  UNLOCK_LOAD    = 5'h10;
   localparam int          RESET_MIN_NS   = 500;
   localparam int          RESET_MIN_CYC  =
      (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int          RECOVER_US     = 2000;
   localparam int          RECOVER_CYC    =
      (RECOVER_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int          SETTLE_US      = 200;
   localparam int          SETTLE_CYC     =
      (SETTLE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // ==========================================================
   // Automatic operations
   localparam logic [1:0]  OP_PAGE_PROG   = 2'h0;
   localparam logic [1:0]  OP_CHIP_ERASE  = 2'h1;
   localparam logic [1:0]  OP_BLOCK_ERASE = 2'h2;

   typedef enum logic [2:0] {
      FCSP_ST_READY  = 3'h1,
      FCSP_ST_BUSY   = 3'h2,
      FCSP_ST_FAILED = 3'h4
   } fcsp_state_e;

endpackage

// file: core/fcsp_timer.sv
// Down counter that holds a busy level for a loaded number of cycles
`timescale 1ns/1ns
module fcsp_timer #(
   parameter int CNT_W = 16,
   parameter int LOAD  = 50000
) (
   input  wire logic core_clk,
   input  wire logic rst_n,
   input  wire logic start,
   output logic      running
);

   localparam logic [CNT_W-1:0] LOAD_V = CNT_W'(LOAD);

   logic [CNT_W-1:0] count_q;

   // ==========================================================
   // Counter
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         count_q <= '0;
      end else if (start) begin
         count_q <= LOAD_V;
      end else if (count_q != '0) begin
         count_q <= count_q - CNT_W'(1);
      end
   end

   assign running = (count_q != '0);

endmodule

// file: core/fcsp_top.sv
// Control, status and protect front end of the flash program/erase sequencer
`timescale 1ns/1ns
// Overview of operation
// - Ready/busy flag reads 0 while an automatic operation runs.
// - Successful completion sets flag to 1; next command is accepted.
// - Failed operation keeps flag at 0 until hardware reset.
// - Command while busy is dropped; later commands refused until reset.
// - Reset without cold start during an operation blocks array reads for about 2 ms.
// - Security enable bit 0 is read/write; 1 enables, 0 disables.
// - Security register reset only by cold start, enable comes up 1.
// - Protect status bits 3..0 report each block; 1 is protected.
// - Programming a protected block is refused.
// - Protect status loads stored non-volatile bits after reset.
// - No array data to reads or fetches during write or erase.
// - A complete command runs internally with no software help.
// - Page program, whole-array erase and single block erase exist.
// - Write and erase are inhibited per protected block.
// - Security at 0x10, status at 0x20, protect status at 0x30.
// - Security active only with enable 1 and all blocks protected.
// - Out-of-order command cycles abandon command, back to read mode.
// - Accepted final command write starts operation, clears flag.
module fcsp_top #(
   parameter int RECOVER_CYC = fcsp_pkg::RECOVER_CYC,
   parameter int NBLK        = fcsp_pkg::NUM_BLOCKS
) (
   input  wire logic        core_clk,
   input  wire logic        rst_n,
   input  wire logic        cold_start_reset_n,
   input  wire logic [7:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [31:0] reg_rdata,
   input  wire logic        cmd_start,
   input  wire logic [1:0]  cmd_op,
   input  wire logic [1:0]  cmd_block,
   input  wire logic        cmd_seq_error,
   input  wire logic        op_done,
   input  wire logic        op_fail,
   input  wire logic [3:0]  nv_protect,
   output logic             op_go,
   output logic      [1:0]  op_kind,
   output logic      [3:0]  op_block_mask,
   output logic             ready_busy_flag,
   output logic             array_read_enable,
   output logic             security_active,
   output logic             cmd_refused,
   output logic             cmd_abandoned
);

   // ==========================================================
   // Helpers
   function automatic logic [3:0] target_mask(
      input logic [1:0] op,
      input logic [1:0] blk,
      input logic [3:0] prot
   );
      logic [3:0] m;
      m = 4'h0;
      if (op == fcsp_pkg::OP_CHIP_ERASE) begin
         m = ~prot;
      end else if (op == fcsp_pkg::OP_PAGE_PROG ||
                   op == fcsp_pkg::OP_BLOCK_ERASE) begin
         m = (4'h1 << blk) & ~prot;
      end
      return m;
   endfunction

   fcsp_pkg::fcsp_state_e state_q;
   fcsp_pkg::fcsp_state_e state_d;
   logic [3:0]  prot_q;
   logic        prot_load_q;
   logic        sec_q;
   logic [4:0]  unlock_cnt_q;
   logic        lockout_q;
   logic        op_mark_q;
   logic        boot_q;
   logic        recover_start;
   logic        recovering;
   logic [3:0]  cand_mask;
   logic        accept;
   logic        busy_cmd;
   logic        sec_active_d;

   assign cand_mask    = target_mask(cmd_op, cmd_block, prot_q);
   assign sec_active_d = sec_q & (&prot_q);
   assign busy_cmd     = cmd_start & (state_q != fcsp_pkg::FCSP_ST_READY);
   assign accept = cmd_start & (state_q == fcsp_pkg::FCSP_ST_READY) &
                   !lockout_q & !security_active & !cmd_seq_error &
                   (cand_mask != 4'h0);

   // ==========================================================
   // Sequencer state
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         fcsp_pkg::FCSP_ST_READY: begin
            if (accept) begin
               state_d = fcsp_pkg::FCSP_ST_BUSY;
            end
         end
         fcsp_pkg::FCSP_ST_BUSY: begin
            if (op_fail) begin
               state_d = fcsp_pkg::FCSP_ST_FAILED;
            end else if (op_done) begin
               state_d = fcsp_pkg::FCSP_ST_READY;
            end
         end
         fcsp_pkg::FCSP_ST_FAILED: begin
            state_d = fcsp_pkg::FCSP_ST_FAILED;
         end
         default: begin
            state_d = fcsp_pkg::FCSP_ST_READY;
         end
      endcase
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= fcsp_pkg::FCSP_ST_READY;
      end else begin
         state_q <= state_d;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         ready_busy_flag <= fcsp_pkg::OP_STATUS_RST[fcsp_pkg::READY_BIT];
      end else begin
         ready_busy_flag <= (state_d == fcsp_pkg::FCSP_ST_READY);
      end
   end

   // ==========================================================
   // Operation launch
   // Launch internal operation
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         op_go         <= 1'b0;
         op_kind       <= fcsp_pkg::OP_PAGE_PROG;
         op_block_mask <= 4'h0;
      end else begin
         op_go <= accept;
         if (accept) begin
            op_kind       <= cmd_op;
            op_block_mask <= cand_mask;
         end
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         lockout_q <= 1'b0;
      end else if (busy_cmd) begin
         lockout_q <= 1'b1;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         cmd_refused   <= 1'b0;
         cmd_abandoned <= 1'b0;
      end else begin
         cmd_refused   <= cmd_start & !accept;
         cmd_abandoned <= cmd_seq_error &
                          (state_q == fcsp_pkg::FCSP_ST_READY);
      end
   end

   // ==========================================================
   // Protect status
   // Load stored protect bits
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         prot_load_q <= 1'b1;
         prot_q      <= 4'h0;
      end else begin
         prot_load_q <= 1'b0;
         if (prot_load_q || (op_done && !op_fail)) begin
            prot_q <= nv_protect;
         end
      end
   end

   // ==========================================================
   // Security register
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         unlock_cnt_q <= 5'h0;
      end else if (reg_wr && reg_addr == fcsp_pkg::SEC_CTRL_OFS) begin
         unlock_cnt_q <= (reg_wdata == fcsp_pkg::UNLOCK_CODE) ?
                         fcsp_pkg::UNLOCK_LOAD : 5'h0;
      end else if (unlock_cnt_q != 5'h0) begin
         unlock_cnt_q <= unlock_cnt_q - 5'h1;
      end
   end

   always_ff @(posedge core_clk or negedge cold_start_reset_n) begin
      if (!cold_start_reset_n) begin
         sec_q <= fcsp_pkg::SEC_CTRL_RST[fcsp_pkg::SEC_EN_BIT];
      end else if (reg_wr && reg_addr == fcsp_pkg::SEC_CTRL_OFS &&
                   unlock_cnt_q != 5'h0 &&
                   reg_wdata != fcsp_pkg::UNLOCK_CODE) begin
         sec_q <= reg_wdata[fcsp_pkg::SEC_EN_BIT];
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         security_active <= 1'b0;
      end else begin
         security_active <= sec_active_d;
      end
   end

   // ==========================================================
   // Reset recovery and read gating
   always_ff @(posedge core_clk or negedge cold_start_reset_n) begin
      if (!cold_start_reset_n) begin
         op_mark_q <= 1'b0;
      end else if (accept) begin
         op_mark_q <= 1'b1;
      end else if (recovering ||
                   (state_q == fcsp_pkg::FCSP_ST_BUSY && op_done &&
                    !op_fail)) begin
         op_mark_q <= 1'b0;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         boot_q <= 1'b1;
      end else begin
         boot_q <= 1'b0;
      end
   end

   assign recover_start = boot_q & op_mark_q;

   fcsp_timer #(
      .CNT_W (16),
      .LOAD  (RECOVER_CYC)
   ) u_recover (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .start    (recover_start),
      .running  (recovering)
   );

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         array_read_enable <= 1'b0;
      end else begin
         array_read_enable <= (state_d == fcsp_pkg::FCSP_ST_READY) &&
                              !recovering && !recover_start && !boot_q;
      end
   end

   // ==========================================================
   // Register read port
   // Address decode
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata <= 32'h0000_0000;
      end else if (reg_rd) begin
         unique case (reg_addr)
            fcsp_pkg::SEC_CTRL_OFS:  reg_rdata <= {31'h0, sec_q};
            fcsp_pkg::OP_STATUS_OFS: reg_rdata <= {31'h0, ready_busy_flag};
            fcsp_pkg::PROT_STAT_OFS: reg_rdata <= {28'h0, prot_q};
            default:                 reg_rdata <= 32'h0000_0000;
         endcase
      end else begin
         reg_rdata <= 32'h0000_0000;
      end
   end

   // ==========================================================
   // Assertions
   sequence s_start;
      accept;
   endsequence

   sequence s_busy_then_ok;
      state_q == fcsp_pkg::FCSP_ST_BUSY && op_done && !op_fail;
   endsequence

   a_busy_flag_low: assert property (@(posedge core_clk) disable iff (!rst_n)
      s_start |=> !ready_busy_flag && op_go)
      else $error("flag not low after start");

   a_done_sets_ready: assert property (@(posedge core_clk) disable iff (!rst_n)
      s_busy_then_ok |=> ready_busy_flag && state_q == fcsp_pkg::FCSP_ST_READY)
      else $error("ready not restored");

   a_fail_holds_busy: assert property (@(posedge core_clk) disable iff (!rst_n)
      state_q == fcsp_pkg::FCSP_ST_FAILED |=> !ready_busy_flag [*4])
      else $error("failed state left busy");

   a_busy_cmd_lock: assert property (@(posedge core_clk) disable iff (!rst_n)
      busy_cmd |=> lockout_q && !op_go && cmd_refused)
      else $error("busy command not dropped");

   a_prot_refuse: assert property (@(posedge core_clk) disable iff (!rst_n)
      cmd_start && cmd_op == fcsp_pkg::OP_PAGE_PROG && prot_q[cmd_block]
      |=> !op_go)
      else $error("protected block programmed");

   a_no_read_busy: assert property (@(posedge core_clk) disable iff (!rst_n)
      !ready_busy_flag |-> !array_read_enable)
      else $error("array readable while busy");

   a_unlock_needed: assert property (@(posedge core_clk) disable iff (!rst_n)
      reg_wr && reg_addr == fcsp_pkg::SEC_CTRL_OFS && unlock_cnt_q == 5'h0
      |=> $stable(sec_q))
      else $error("security bit changed without unlock");

   a_sec_active: assert property (@(posedge core_clk) disable iff (!rst_n)
      ##1 security_active == $past(sec_q & (&prot_q)))
      else $error("security active mismatch");

   a_status_zero: assert property (@(posedge core_clk) disable iff (!rst_n)
      reg_rd && reg_addr == fcsp_pkg::OP_STATUS_OFS
      |=> reg_rdata[31:1] == 31'h0 && reg_rdata[0] == $past(ready_busy_flag))
      else $error("status read wrong");

   a_recover_block: assert property (@(posedge core_clk) disable iff (!rst_n)
      recover_start |=> !array_read_enable [*8])
      else $error("reads open during recovery");

endmodule

// file: sim/fcsp_engine_model.sv
// Behavioural model of the array engine behind the sequencer
`timescale 1ns/1ns
module fcsp_engine_model #(
   parameter int FAST = 8,
   parameter int SLOW = 40
) (
   input  wire logic       core_clk,
   input  wire logic       rst_n,
   input  wire logic       op_go,
   input  wire logic [1:0] op_kind,
   input  wire logic       fail_mode,
   output logic            op_done,
   output logic            op_fail
);
   // ==========================================================
   // Operation timer
   int cnt_q;
   // Runs each started kind alone, chip erase slower
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q   <= 0;
         op_done <= 1'b0;
         op_fail <= 1'b0;
      end else begin
         op_done <= 1'b0;
         op_fail <= 1'b0;
         if (op_go) begin
            cnt_q <= (op_kind == fcsp_pkg::OP_CHIP_ERASE) ? SLOW : FAST;
         end else if (cnt_q == 1) begin
            op_done <= 1'b1;
            op_fail <= fail_mode;
            cnt_q   <= 0;
         end else if (cnt_q > 1) begin
            cnt_q <= cnt_q - 1;
         end
      end
   end
endmodule

// file: sim/testbench.sv
// Self-checking bench of the flash control, status and protect block
`timescale 1ns/1ns
module testbench;
   logic        core_clk = 1'b0;
   logic        rst_n, cold_start_reset_n, reg_wr, reg_rd, cmd_start;
   logic        cmd_seq_error, op_done, op_fail, op_go, ready_busy_flag;
   logic        array_read_enable, security_active, cmd_refused;
   logic        cmd_abandoned, fail_mode;
   logic [7:0]  reg_addr;
   logic [31:0] reg_wdata, reg_rdata, rd;
   logic [1:0]  cmd_op, cmd_block, op_kind, kind_seen;
   logic [3:0]  nv_protect, op_block_mask, mask_seen;
   int          bad_count = 0;
   int          check_count = 0;
   int          cycles = 0;
   int          go_n = 0;
   int          ref_n = 0;
   int          abn_n = 0;
   int          g, r;
   logic [1:0]  t_op [3] = '{fcsp_pkg::OP_PAGE_PROG,
                              fcsp_pkg::OP_CHIP_ERASE,
                              fcsp_pkg::OP_BLOCK_ERASE};
   logic [1:0]  t_blk [3] = '{2'h1, 2'h0, 2'h3};
   logic [3:0]  t_mask [3] = '{4'h2, 4'hA, 4'h8};

   fcsp_top #(.RECOVER_CYC(20)) fcsp_top_i (.core_clk(core_clk),
      .rst_n(rst_n), .cold_start_reset_n(cold_start_reset_n),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cmd_start(cmd_start),
      .cmd_op(cmd_op), .cmd_block(cmd_block),
      .cmd_seq_error(cmd_seq_error), .op_done(op_done),
      .op_fail(op_fail), .nv_protect(nv_protect), .op_go(op_go),
      .op_kind(op_kind), .op_block_mask(op_block_mask),
      .ready_busy_flag(ready_busy_flag),
      .array_read_enable(array_read_enable),
      .security_active(security_active), .cmd_refused(cmd_refused),
      .cmd_abandoned(cmd_abandoned));
   fcsp_engine_model fcsp_engine_model_i (.core_clk(core_clk),
      .rst_n(rst_n), .op_go(op_go), .op_kind(op_kind),
      .fail_mode(fail_mode), .op_done(op_done), .op_fail(op_fail));

   // ==========================================================
   // Clock, monitor and timeout
   always #20 core_clk = ~core_clk;
   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (op_go === 1'b1) begin
         go_n      <= go_n + 1;
         kind_seen <= op_kind;
         mask_seen <= op_block_mask;
      end
      if (cmd_refused === 1'b1) ref_n <= ref_n + 1;
      if (cmd_abandoned === 1'b1) abn_n <= abn_n + 1;
      if (cycles == 20000) begin
         bad_count = bad_count + 1;
         print_verdict();
      end
   end

   // ==========================================================
   // Tasks
   task automatic check(input string what, input logic [31:0] seen,
                        input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic reg_read(input logic [7:0] a);
      @(posedge core_clk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1 rd = reg_rdata;
   endtask
   task automatic command(input logic s, input logic e,
                          input logic [1:0] op, input logic [1:0] b);
      g = go_n;
      r = ref_n;
      @(posedge core_clk);
      cmd_start     <= s;
      cmd_seq_error <= e;
      cmd_op        <= op;
      cmd_block     <= b;
      @(posedge core_clk);
      cmd_start     <= 1'b0;
      cmd_seq_error <= 1'b0;
      repeat (2) @(posedge core_clk);
   endtask
   task automatic wait_ready();
      rd = 32'h0;
      for (int i = 0; i < 40 && rd[0] !== 1'b1; i++) reg_read(8'h20);
      check("ready wait", rd, 32'h1);
   endtask
   task automatic sec_write(input logic [31:0] d);
      reg_write(fcsp_pkg::SEC_CTRL_OFS, fcsp_pkg::UNLOCK_CODE);
      reg_write(fcsp_pkg::SEC_CTRL_OFS, d);
   endtask
   task automatic do_reset(input logic cold);
      @(posedge core_clk);
      rst_n              <= 1'b0;
      cold_start_reset_n <= ~cold;
      repeat (fcsp_pkg::RESET_MIN_CYC) @(posedge core_clk);
      rst_n              <= 1'b1;
      cold_start_reset_n <= 1'b1;
      repeat (3) @(posedge core_clk);
   endtask
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   // ==========================================================
   // Test sequence
   initial begin
      {reg_wr, reg_rd, cmd_start, cmd_seq_error, fail_mode} = '0;
      {reg_addr, reg_wdata, cmd_op, cmd_block} = '0;
      rst_n = 1'b0;
      cold_start_reset_n = 1'b0;
      nv_protect = 4'h5;
      repeat (3) @(posedge core_clk);
      rst_n <= 1'b1;
      cold_start_reset_n <= 1'b1;
      repeat (2) @(posedge core_clk);
      reg_read(8'h10); check("security_control", rd, 32'h1);
      reg_read(8'h20); check("status", rd, 32'h1);
      reg_read(8'h30); check("protect", rd, 32'h5);
      reg_read(8'h40); check("unmapped", rd, 32'h0);
      check("read enable", 32'(array_read_enable), 32'h1);
      check("sec active", 32'(security_active), 32'h0);
      $display("test reset_values done");
      reg_write(8'h10, 32'h0);
      reg_read(8'h10); check("sec no unlock", rd, 32'h1);
      sec_write(32'hFFFF_FFFE);
      reg_read(8'h10); check("sec cleared", rd, 32'h0);
      reg_write(8'h10, fcsp_pkg::UNLOCK_CODE);
      repeat (17) @(posedge core_clk);
      reg_write(8'h10, 32'hFFFF_FFFF);
      reg_read(8'h10); check("sec late", rd, 32'h0);
      do_reset(1'b0);
      reg_read(8'h10); check("sec warm reset", rd, 32'h0);
      sec_write(32'hFFFF_FFFF);
      reg_read(8'h10); check("sec set", rd, 32'h1);
      reg_write(8'h20, 32'h0);
      reg_write(8'h30, 32'hF);
      reg_read(8'h20); check("status ro", rd, 32'h1);
      reg_read(8'h30); check("protect ro", rd, 32'h5);
      $display("test registers done");
      for (int i = 0; i < 3; i++) begin
         wait_ready();
         command(1'b1, 1'b0, t_op[i], t_blk[i]);
         if (i == 2) nv_protect <= 4'h3;
         check("go", 32'(go_n), 32'(g + 1));
         check("kind", 32'(kind_seen), 32'(t_op[i]));
         check("mask", 32'(mask_seen), 32'(t_mask[i]));
         check("read enable busy", 32'(array_read_enable), 32'h0);
         reg_read(8'h20); check("busy", rd, 32'h0);
         wait_ready();
         check("read enable idle", 32'(array_read_enable), 32'h1);
         reg_read(8'h30); check("prot", rd, (i == 2) ? 32'h3 : 32'h5);
      end
      $display("test operations done");
      command(1'b1, 1'b0, fcsp_pkg::OP_PAGE_PROG, 2'h0);
      check("prot page", 32'(ref_n), 32'(r + 1));
      command(1'b1, 1'b0, fcsp_pkg::OP_BLOCK_ERASE, 2'h1);
      check("prot erase", 32'(ref_n), 32'(r + 1));
      command(1'b1, 1'b0, 2'h3, 2'h2);
      check("bad op", 32'(ref_n), 32'(r + 1));
      command(1'b1, 1'b1, fcsp_pkg::OP_PAGE_PROG, 2'h2);
      check("seq err start", 32'(ref_n), 32'(r + 1));
      command(1'b0, 1'b1, fcsp_pkg::OP_PAGE_PROG, 2'h2);
      check("abandons", 32'(abn_n), 32'h2);
      check("no go", 32'(go_n), 32'h3);
      $display("test refusals done");
      command(1'b1, 1'b0, fcsp_pkg::OP_PAGE_PROG, 2'h2);
      command(1'b1, 1'b0, fcsp_pkg::OP_PAGE_PROG, 2'h3);
      check("busy cmd", 32'(ref_n), 32'(r + 1));
      wait_ready();
      command(1'b1, 1'b0, fcsp_pkg::OP_PAGE_PROG, 2'h3);
      check("lockout", 32'(ref_n), 32'(r + 1));
      do_reset(1'b0);
      command(1'b1, 1'b0, fcsp_pkg::OP_PAGE_PROG, 2'h3);
      check("after reset", 32'(go_n), 32'(g + 1));
      wait_ready();
      $display("test lockout done");
      fail_mode <= 1'b1;
      command(1'b1, 1'b0, fcsp_pkg::OP_PAGE_PROG, 2'h2);
      repeat (60) @(posedge core_clk);
      reg_read(8'h20); check("failed", rd, 32'h0);
      fail_mode <= 1'b0;
      do_reset(1'b0);
      check("recover hold", 32'(array_read_enable), 32'h0);
      reg_read(8'h20); check("reset ready", rd, 32'h1);
      repeat (25) @(posedge core_clk);
      check("recovered", 32'(array_read_enable), 32'h1);
      repeat (fcsp_pkg::SETTLE_CYC) @(posedge core_clk);
      $display("test failure done");
      nv_protect <= 4'hF;
      do_reset(1'b1);
      check("sec on", 32'(security_active), 32'h1);
      command(1'b1, 1'b0, fcsp_pkg::OP_CHIP_ERASE, 2'h0);
      check("sec refuse", 32'(ref_n), 32'(r + 1));
      sec_write(32'h0);
      repeat (2) @(posedge core_clk);
      check("sec off", 32'(security_active), 32'h0);
      $display("test security done");
      print_verdict();
   end
endmodule
